// >>> src/iopa_pkg.sv
// constants, types and cycle encodings shared by both ends of the port bus
// Operation
// - separate 64K byte port space, 0 to ffff
// - no port placed at 00f8 through 00ff
// - adjacent byte ports form 16 or 32 bits
// - wide ports sit on aligned addresses
// - unaligned ports finished with extra bus cycles
// - far side ignores order of split cycles
// - parity errors on port cycles never masked
// - port writes finish before next instruction
// - memory select high memory, low port
// - far side decodes port space separately
// - memory-mapped port range kept uncacheable
// - inactive cache allow blocks all caching
// - page cache disable flag blocks caching
// - port operations never reach memory space
// - single item uses 8, 16, 32 accumulator
// - port from immediate or data counter
// - string ops: data counter, source/destination
// - repeat steps pointer by size, direction flag
`default_nettype none
package iopa_pkg;
    localparam int          IOPA_PORT_AW   = 16;
    localparam logic [15:0] IOPA_PORT_TOP  = 16'hffff;
    localparam logic [15:0] IOPA_RSV_LO    = 16'h00f8;
    localparam logic [15:0] IOPA_RSV_HI    = 16'h00ff;
    localparam logic        IOPA_SEL_MEM   = 1'b1;
    localparam logic        IOPA_SEL_PORT  = 1'b0;
    localparam logic [31:0] IOPA_WORD_STEP = 32'h0000_0004;
    // far end defaults: port window, memory-mapped window, scratch memory
    localparam logic [15:0] IOPA_IO_BASE   = 16'h0300;
    localparam int          IOPA_PORT_WDS  = 4;
    localparam logic [31:0] IOPA_MMIO_BASE = 32'h0001_0000;
    localparam int          IOPA_MEM_WDS   = 16;

    typedef enum logic [2:0] {
        OP_PORT_IN,
        OP_PORT_OUT,
        OP_PORT_STRING_READ,
        OP_PORT_STRING_WRITE,
        OP_MEM_READ,
        OP_MEM_WRITE
    } iopa_op_e;

    typedef enum logic [1:0] {
        SZ_8,
        SZ_16,
        SZ_32
    } iopa_size_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PORT,
        ST_MEM
    } iopa_state_e;

    // bytes moved by one item of the given size
    function automatic logic [2:0] iopa_bytes(input iopa_size_e s);
        case (s)
            SZ_8:    iopa_bytes = 3'd1;
            SZ_16:   iopa_bytes = 3'd2;
            default: iopa_bytes = 3'd4;
        endcase
    endfunction
endpackage
`default_nettype wire

// >>> src/iopa_bus_if.sv
// bus between the port access unit and the external decode logic
`timescale 1ns/10ps
`default_nettype none
interface iopa_bus_if;
    logic        req;           // cycle in progress
    logic        wr;            // write cycle
    logic        m_io;          // 1 memory, 0 port space
    logic        cacheable;     // page allows caching
    logic [31:0] addr;          // word-aligned byte address
    logic [3:0]  be;            // byte lanes used
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        rpar;          // odd parity over rdata
    logic        ready;         // cycle completes this clock
    logic        cache_allow_n; // low lets the line be cached

    modport cpu (
        output req, wr, m_io, cacheable, addr, be, wdata,
        input  rdata, rpar, ready, cache_allow_n
    );
    modport sys (
        input  req, wr, m_io, cacheable, addr, be, wdata,
        output rdata, rpar, ready, cache_allow_n
    );
endinterface
`default_nettype wire

// >>> src/iopa_lane_split.sv
// byte-lane placement of one item over one or two aligned bus words
`timescale 1ns/10ps
`default_nettype none
module iopa_lane_split
    import iopa_pkg::*;
(
    input  wire logic [1:0]  off_i,
    input  wire iopa_size_e  size_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic [31:0] rd_lo_i,
    input  wire logic [31:0] rd_hi_i,
    output logic      [3:0]  be_lo_o,
    output logic      [3:0]  be_hi_o,
    output logic             two_o,
    output logic      [31:0] wd_lo_o,
    output logic      [31:0] wd_hi_o,
    output logic      [31:0] rdata_o
);
    logic [7:0]  mask;
    logic [7:0]  lanes;
    logic [31:0] keep;
    logic [63:0] wspan;
    logic [63:0] rspan;
    logic [5:0]  sh;

    // lane mask of the item width
    always_comb begin
        case (size_i)
            SZ_8: begin
                mask = 8'h01;
                keep = 32'h0000_00ff;
            end
            SZ_16: begin
                mask = 8'h03;
                keep = 32'h0000_ffff;
            end
            default: begin
                mask = 8'h0f;
                keep = 32'hffff_ffff;
            end
        endcase
    end

    // shift into a two-word span; upper lanes spill to a second cycle
    assign sh      = {1'b0, off_i, 3'b000};
    assign lanes   = mask << off_i;
    assign be_lo_o = lanes[3:0];
    assign be_hi_o = lanes[7:4];
    assign two_o   = |lanes[7:4];
    assign wspan   = {32'h0, wdata_i} << sh;
    assign wd_lo_o = wspan[31:0];
    assign wd_hi_o = wspan[63:32];
    assign rspan   = {rd_hi_i, rd_lo_i} >> sh;
    assign rdata_o = rspan[31:0] & keep;
endmodule
`default_nettype wire

// >>> src/iopa_cpu.sv
// processor-side port access unit: single and string port operations
`timescale 1ns/10ps
`default_nettype none
module iopa_cpu
    import iopa_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    iopa_bus_if.cpu          bus,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire iopa_op_e    cmd_op_i,
    input  wire iopa_size_e  cmd_size_i,
    input  wire logic        repeat_prefix_i,
    input  wire logic        cmd_use_imm_i,
    input  wire logic [7:0]  cmd_imm_port_i,
    input  wire logic [15:0] data_counter_reg_i,
    input  wire logic [31:0] accumulator_32_i,
    input  wire logic [31:0] count_i,
    input  wire logic [31:0] source_pointer_i,
    input  wire logic [31:0] destination_pointer_i,
    input  wire logic        direction_flag_i,
    input  wire logic [31:0] mem_addr_i,
    input  wire logic        page_cache_disable_flag_i,
    output logic             done_o,
    output logic      [31:0] accumulator_32_o,
    output logic      [31:0] source_pointer_o,
    output logic      [31:0] destination_pointer_o,
    output logic      [31:0] count_o,
    output logic             parity_err_o,
    output logic             cached_o
);
    iopa_state_e state_reg;
    iopa_state_e state_next;
    iopa_op_e    op_reg;
    iopa_size_e  size_reg;
    logic        rpt_reg;
    logic        dn_reg;
    logic        unc_reg;
    logic        half_reg;
    logic [15:0] port_reg;
    logic [31:0] acc_reg;
    logic [31:0] si_reg;
    logic [31:0] di_reg;
    logic [31:0] cnt_reg;
    logic [31:0] maddr_reg;
    logic [31:0] data_reg;
    logic [31:0] rd0_reg;
    logic        done_reg;
    logic        perr_reg;
    logic        cached_reg;
    logic [31:0] cur_addr;
    logic [31:0] word_addr;
    logic [31:0] step;
    logic [31:0] merged;
    logic [31:0] acc_sized;
    logic [31:0] wd_lo;
    logic [31:0] wd_hi;
    logic [3:0]  be_lo;
    logic [3:0]  be_hi;
    logic        two;
    logic        xfer;
    logic        last;
    logic        rd_phase;
    logic        is_str;
    logic        start;
    logic        skip;
    logic        item_end;
    logic        more;

    // command acceptance; a repeated string op with zero count does nothing
    assign cmd_ready_o = (state_reg == ST_IDLE);
    assign start       = cmd_ready_o && cmd_valid_i;
    assign is_str      = (cmd_op_i == OP_PORT_STRING_READ) ||
                         (cmd_op_i == OP_PORT_STRING_WRITE);
    assign skip        = start && is_str && repeat_prefix_i &&
                         (count_i == 32'h0);

    // address of the current phase: port numbers stay inside 64K
    always_comb begin
        if (state_reg == ST_PORT) begin
            cur_addr = {16'h0, port_reg};
        end else if (op_reg == OP_PORT_STRING_WRITE) begin
            cur_addr = si_reg;
        end else if (op_reg == OP_PORT_STRING_READ) begin
            cur_addr = di_reg;
        end else begin
            cur_addr = maddr_reg;
        end
    end

    // read or write direction of the current phase
    always_comb begin
        if (state_reg == ST_PORT) begin
            rd_phase = (op_reg == OP_PORT_IN) ||
                       (op_reg == OP_PORT_STRING_READ);
        end else begin
            rd_phase = (op_reg == OP_MEM_READ) ||
                       (op_reg == OP_PORT_STRING_WRITE);
        end
    end

    iopa_lane_split u_split (
        .off_i   (cur_addr[1:0]),
        .size_i  (size_reg),
        .wdata_i (data_reg),
        .rd_lo_i (half_reg ? rd0_reg : bus.rdata),
        .rd_hi_i (bus.rdata),
        .be_lo_o (be_lo),
        .be_hi_o (be_hi),
        .two_o   (two),
        .wd_lo_o (wd_lo),
        .wd_hi_o (wd_hi),
        .rdata_o (merged)
    );

    // bus cycle drive; second word of a split item follows the first
    assign word_addr = {cur_addr[31:2], 2'b00} +
                       (half_reg ? IOPA_WORD_STEP : 32'h0);
    assign bus.req   = (state_reg != ST_IDLE);
    assign bus.wr    = bus.req && !rd_phase;
    assign bus.m_io  = (state_reg == ST_MEM) ? IOPA_SEL_MEM
                                             : IOPA_SEL_PORT;
    assign bus.addr  = (state_reg == ST_PORT) ? {16'h0, word_addr[15:0]}
                                              : word_addr;
    assign bus.be    = half_reg ? be_hi : be_lo;
    assign bus.wdata = half_reg ? wd_hi : wd_lo;
    assign bus.cacheable = (state_reg == ST_MEM) && !unc_reg;

    assign xfer     = bus.req && bus.ready;
    assign last     = xfer && (!two || half_reg);
    assign item_end = last &&
        (((op_reg == OP_PORT_STRING_WRITE) && (state_reg == ST_PORT)) ||
         ((op_reg == OP_PORT_STRING_READ) && (state_reg == ST_MEM)));
    assign more     = rpt_reg && (cnt_reg != 32'h1);
    assign step     = {29'h0, iopa_bytes(size_reg)};

    // accumulator keeps the bits above the item width
    always_comb begin
        case (size_reg)
            SZ_8:    acc_sized = {acc_reg[31:8], merged[7:0]};
            SZ_16:   acc_sized = {acc_reg[31:16], merged[15:0]};
            default: acc_sized = merged;
        endcase
    end

    // phase sequencing; done only after the last cycle has completed
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start && !skip) begin
                    if ((cmd_op_i == OP_PORT_STRING_WRITE) ||
                        (cmd_op_i == OP_MEM_READ) ||
                        (cmd_op_i == OP_MEM_WRITE)) begin
                        state_next = ST_MEM;
                    end else begin
                        state_next = ST_PORT;
                    end
                end
            end
            ST_PORT: begin
                if (last) begin
                    if (op_reg == OP_PORT_STRING_READ) begin
                        state_next = ST_MEM;
                    end else if (item_end && more) begin
                        state_next = ST_MEM;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_MEM: begin
                if (last) begin
                    if (op_reg == OP_PORT_STRING_WRITE) begin
                        state_next = ST_PORT;
                    end else if (item_end && more) begin
                        state_next = ST_PORT;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // state and split-cycle half
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            half_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (xfer) begin
                half_reg <= !last;
            end
        end
    end

    // command latch, data movement and pointer stepping
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            op_reg    <= OP_PORT_IN;
            size_reg  <= SZ_8;
            rpt_reg   <= 1'b0;
            dn_reg    <= 1'b0;
            unc_reg   <= 1'b0;
            port_reg  <= 16'h0;
            acc_reg   <= 32'h0;
            si_reg    <= 32'h0;
            di_reg    <= 32'h0;
            cnt_reg   <= 32'h0;
            maddr_reg <= 32'h0;
            data_reg  <= 32'h0;
            rd0_reg   <= 32'h0;
        end else if (start) begin
            op_reg    <= cmd_op_i;
            size_reg  <= cmd_size_i;
            rpt_reg   <= repeat_prefix_i;
            dn_reg    <= direction_flag_i;
            unc_reg   <= page_cache_disable_flag_i;
            port_reg  <= (cmd_use_imm_i && !is_str) ?
                         {8'h0, cmd_imm_port_i} :
                         data_counter_reg_i;
            acc_reg   <= accumulator_32_i;
            si_reg    <= source_pointer_i;
            di_reg    <= destination_pointer_i;
            cnt_reg   <= count_i;
            maddr_reg <= mem_addr_i;
            data_reg  <= accumulator_32_i;
        end else begin
            if (xfer && !last) begin
                rd0_reg <= bus.rdata;
            end
            if (last && rd_phase) begin
                if ((op_reg == OP_PORT_IN) || (op_reg == OP_MEM_READ)) begin
                    acc_reg <= acc_sized;
                end else begin
                    data_reg <= merged;
                end
            end
            if (item_end) begin
                if (op_reg == OP_PORT_STRING_WRITE) begin
                    si_reg <= dn_reg ? si_reg - step
                                     : si_reg + step;
                end else begin
                    di_reg <= dn_reg ? di_reg - step
                                     : di_reg + step;
                end
                if (rpt_reg) begin
                    cnt_reg <= cnt_reg - 32'h1;
                end
            end
        end
    end

    // completion, parity and cache-fill pulses
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            done_reg   <= 1'b0;
            perr_reg   <= 1'b0;
            cached_reg <= 1'b0;
        end else begin
            done_reg   <= skip || (last && (state_next == ST_IDLE));
            perr_reg   <= xfer && rd_phase &&
                          ((^bus.rdata) == bus.rpar);
            cached_reg <= xfer && rd_phase && (state_reg == ST_MEM) &&
                          !unc_reg && !bus.cache_allow_n;
        end
    end

    assign done_o                = done_reg;
    assign accumulator_32_o      = acc_reg;
    assign source_pointer_o      = si_reg;
    assign destination_pointer_o = di_reg;
    assign count_o               = cnt_reg;
    assign parity_err_o          = perr_reg;
    assign cached_o              = cached_reg;
endmodule
`default_nettype wire

// >>> src/iopa_sys.sv
// external decode logic with peripheral port registers and scratch memory
`timescale 1ns/10ps
`default_nettype none
module iopa_sys
    import iopa_pkg::*;
#(
    parameter logic [15:0] IO_BASE    = IOPA_IO_BASE,
    parameter int          PORT_WDS   = IOPA_PORT_WDS,
    parameter logic [31:0] MMIO_BASE  = IOPA_MMIO_BASE,
    parameter int          MEM_WDS    = IOPA_MEM_WDS
)(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    iopa_bus_if.sys          bus,
    input  wire logic        par_flip_i,
    output logic             periph_wr_o,
    output logic      [7:0]  periph_idx_o,
    output logic      [31:0] periph_data_o
);
    localparam int PI_W = $clog2(PORT_WDS);
    localparam int MI_W = $clog2(MEM_WDS);

    // port window aligned, inside 64K, clear of the reserved range
    if ((IO_BASE[1:0] != 2'b00) || (PORT_WDS < 2) || (PORT_WDS > 64) ||
        (MEM_WDS < 2) || (MMIO_BASE[1:0] != 2'b00) ||
        ((32'(IO_BASE) + 32'(4 * PORT_WDS)) > 32'(IOPA_PORT_TOP) + 1) ||
        !(((32'(IO_BASE) + 32'(4 * PORT_WDS)) <= 32'(IOPA_RSV_LO)) ||
          (IO_BASE > IOPA_RSV_HI))) begin : g_chk
        $error("iopa_sys: port window parameters not supported");
    end

    logic [31:0]     port_regs [PORT_WDS];
    logic [31:0]     ram [MEM_WDS];
    logic [31:0]     io_off;
    logic [31:0]     mm_off;
    logic [31:0]     word;
    logic [31:0]     rdata_reg;
    logic [PI_W-1:0] pidx;
    logic [MI_W-1:0] midx;
    logic            io_hit;
    logic            mm_hit;
    logic            ram_hit;
    logic            take;
    logic            ready_reg;
    logic            rpar_reg;
    logic            pwr_reg;
    logic [7:0]      pidx_reg;
    logic [31:0]     pdata_reg;

    // decode: port space only on port cycles, memory windows otherwise
    assign io_off  = bus.addr - {16'h0, IO_BASE};
    assign mm_off  = bus.addr - MMIO_BASE;
    assign io_hit  = (bus.m_io == IOPA_SEL_PORT) &&
                     (io_off < 32'(4 * PORT_WDS));
    assign mm_hit  = (bus.m_io == IOPA_SEL_MEM) &&
                     (mm_off < 32'(4 * PORT_WDS));
    assign ram_hit = (bus.m_io == IOPA_SEL_MEM) &&
                     (bus.addr < 32'(4 * MEM_WDS));
    assign pidx    = io_hit ? io_off[PI_W+1:2] : mm_off[PI_W+1:2];
    assign midx    = bus.addr[MI_W+1:2];
    assign word    = (io_hit || mm_hit) ? port_regs[pidx] :
                     ram_hit ? ram[midx] : 32'h0;
    assign take    = bus.req && !ready_reg;

    // caching is only allowed for the scratch memory
    assign bus.cache_allow_n = !ram_hit;

    // each bus cycle served on its own, whatever order they arrive in
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ready_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rpar_reg  <= 1'b1;
            for (int i = 0; i < PORT_WDS; i++) begin
                port_regs[i] <= 32'h0;
            end
            for (int i = 0; i < MEM_WDS; i++) begin
                ram[i] <= 32'h0;
            end
        end else begin
            ready_reg <= take;
            if (take && !bus.wr) begin
                rdata_reg <= word;
                rpar_reg  <= !(^word) ^ par_flip_i;
            end
            for (int b = 0; b < 4; b++) begin
                if (take && bus.wr && bus.be[b]) begin
                    if (io_hit || mm_hit) begin
                        port_regs[pidx][8*b +: 8] <= bus.wdata[8*b +: 8];
                    end else if (ram_hit) begin
                        ram[midx][8*b +: 8] <= bus.wdata[8*b +: 8];
                    end
                end
            end
        end
    end

    // peripheral write notice, one pulse per port register write
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pwr_reg   <= 1'b0;
            pidx_reg  <= 8'h0;
            pdata_reg <= 32'h0;
        end else begin
            pwr_reg <= take && bus.wr && (io_hit || mm_hit);
            if (take && bus.wr && (io_hit || mm_hit)) begin
                pidx_reg  <= 8'(pidx);
                pdata_reg <= bus.wdata;
            end
        end
    end

    assign bus.ready     = ready_reg;
    assign bus.rdata     = rdata_reg;
    assign bus.rpar      = rpar_reg;
    assign periph_wr_o   = pwr_reg;
    assign periph_idx_o  = pidx_reg;
    assign periph_data_o = pdata_reg;
endmodule
`default_nettype wire

// >>> bench/iopa_sva.sv
// checker on the port bus between the access unit and the decode logic
`timescale 1ns/10ps
`default_nettype none
module iopa_sva (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        req,
    input  wire logic        wr,
    input  wire logic        m_io,
    input  wire logic        cacheable,
    input  wire logic [31:0] addr,
    input  wire logic [3:0]  be,
    input  wire logic        ready,
    input  wire logic        cache_allow_n
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // port cycles carry only a 16-bit port number
    property p_space; req && !m_io |-> addr[31:16] == 16'h0000; endproperty
    a_space: assert property (p_space)
        else $error("port cycle beyond 64K");
    // every cycle moves at least one byte lane
    property p_lanes; req |-> be != 4'h0; endproperty
    a_lanes: assert property (p_lanes)
        else $error("cycle with no byte lane");
    // a split part is held steady until it is answered
    property p_hold;
        req && !ready |=> req && $stable(addr) && $stable(be) && $stable(wr);
    endproperty
    a_hold: assert property (p_hold)
        else $error("cycle changed before answer");
    // decode answers one clock later with a single pulse
    property p_answer; req && !ready |=> ready ##1 !ready; endproperty
    a_answer: assert property (p_answer)
        else $error("answer not a one clock pulse");
    // an answer only follows a request held over two clocks
    property p_cause; ready |-> req && $past(req); endproperty
    a_cause: assert property (p_cause)
        else $error("answer without request");
    // a finished cycle is released or replaced by a new one at once
    property p_end;
        req && ready |=> !ready && (!req || $changed({m_io, wr, addr}));
    endproperty
    a_end: assert property (p_end)
        else $error("request held past answer");
    // addresses beyond the port space are always memory cycles
    property p_sel; req && addr[31:16] != 16'h0000 |-> m_io; endproperty
    a_sel: assert property (p_sel)
        else $error("high address flagged as port");
    // port cycles are never offered for caching
    property p_nocache; req && !m_io |-> !cacheable; endproperty
    a_nocache: assert property (p_nocache)
        else $error("port cycle marked cacheable");
    // decode never allows caching of a port cycle
    property p_allow; req && !m_io |-> cache_allow_n; endproperty
    a_allow: assert property (p_allow)
        else $error("caching allowed on port cycle");
endmodule
`default_nettype wire

// >>> bench/iopa_tb.sv
// self-checking bench: both ends joined over the port bus
`timescale 1ns/10ps
`default_nettype none
module iopa_tb;
    import iopa_pkg::*;
    logic        clk_i, rst_n_i, cmd_valid, cmd_ready, rpt, use_imm;
    logic        dn, unc, par_flip, done, perr, cached, pwr, pe, cc, pw;
    iopa_op_e    op;
    iopa_size_e  sz;
    logic [7:0]  imm, pidx;
    logic [15:0] port;
    logic [31:0] acc, cnt, src, dst, maddr, acc_o, src_o, dst_o, cnt_o;
    logic [31:0] pdata;
    int          lat, num_errors, num_checks;
    iopa_bus_if bus_if();
    iopa_cpu iopa_cpu_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(op),
        .cmd_size_i(sz), .repeat_prefix_i(rpt), .cmd_use_imm_i(use_imm),
        .cmd_imm_port_i(imm), .data_counter_reg_i(port),
        .accumulator_32_i(acc), .count_i(cnt), .source_pointer_i(src),
        .destination_pointer_i(dst), .direction_flag_i(dn),
        .mem_addr_i(maddr), .page_cache_disable_flag_i(unc),
        .done_o(done), .accumulator_32_o(acc_o), .source_pointer_o(src_o),
        .destination_pointer_o(dst_o), .count_o(cnt_o),
        .parity_err_o(perr), .cached_o(cached));
    iopa_sys iopa_sys_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus_if),
        .par_flip_i(par_flip), .periph_wr_o(pwr), .periph_idx_o(pidx),
        .periph_data_o(pdata));
    iopa_sva iopa_sva_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .req(bus_if.req), .wr(bus_if.wr), .m_io(bus_if.m_io),
        .cacheable(bus_if.cacheable), .addr(bus_if.addr), .be(bus_if.be),
        .ready(bus_if.ready), .cache_allow_n(bus_if.cache_allow_n));
    // compare one value and count it
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // issue one command and wait for its completion pulse
    task automatic go(input iopa_op_e o, input iopa_size_e s,
                      input logic [15:0] p, input logic [31:0] a);
        @(posedge clk_i);
        op <= o;
        sz <= s;
        port <= p;
        acc <= a;
        cmd_valid <= 1'b1;
        @(posedge clk_i);
        cmd_valid <= 1'b0;
        pe = 1'b0;
        cc = 1'b0;
        pw = 1'b0;
        for (lat = 1; lat <= 60; lat++) begin
            #1;
            pe |= perr;
            cc |= cached;
            if (done === 1'b1) break;
            pw |= pwr;
            @(posedge clk_i);
        end
        chk("done", 32'h1, {31'h0, done});
        chk("ready at done", 32'h1, {31'h0, cmd_ready});
    endtask
    // print counts and the verdict, then stop
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // clock source
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // watchdog against a hung handshake
    initial begin
        #(100 * 3000);
        num_errors++;
        close_out();
    end
    // test sequence
    initial begin
        {rst_n_i, cmd_valid, rpt, use_imm, dn, unc, par_flip} = 7'h00;
        op = OP_PORT_IN;
        sz = SZ_8;
        {imm, port} = '0;
        {acc, cnt, src, dst, maddr} = '0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        go(OP_PORT_OUT, SZ_32, 16'h0300, 32'ha1b2c3d4);
        chk("out latency", 32'd3, lat);
        chk("out written first", 32'h1, {31'h0, pw});
        chk("out data", 32'ha1b2c3d4, pdata);
        go(OP_PORT_OUT, SZ_16, 16'h0303, 32'h0000beef);
        chk("split latency", 32'd5, lat);
        chk("split index", 32'h1, {24'h0, pidx});
        chk("split high", 32'h000000be, pdata);
        go(OP_PORT_IN, SZ_32, 16'h0300, 32'h0);
        chk("word in", 32'hefb2c3d4, acc_o);
        chk("port not cached", 32'h0, {31'h0, cc});
        go(OP_PORT_IN, SZ_16, 16'h0303, 32'h12340000);
        chk("split in", 32'h1234beef, acc_o);
        $display("test widths and split done");
        use_imm <= 1'b1;
        imm <= 8'h10;
        go(OP_PORT_IN, SZ_8, 16'h0300, 32'h55555555);
        chk("immediate port", 32'h55555500, acc_o);
        use_imm <= 1'b0;
        go(OP_MEM_WRITE, SZ_32, 16'h0, 32'h00005a3c);
        maddr <= 32'h4;
        go(OP_MEM_WRITE, SZ_32, 16'h0, 32'h11111111);
        rpt <= 1'b1;
        cnt <= 32'h2;
        go(OP_PORT_STRING_WRITE, SZ_8, 16'h0300, 32'h0);
        chk("src step", 32'h2, src_o);
        chk("count out", 32'h0, cnt_o);
        chk("last item", 32'h5a, pdata & 32'hff);
        dst <= 32'h7;
        dn <= 1'b1;
        go(OP_PORT_STRING_READ, SZ_8, 16'h0300, 32'h0);
        chk("dst step down", 32'h5, dst_o);
        go(OP_MEM_READ, SZ_32, 16'h0, 32'h0);
        chk("mem filled", 32'h5a5a1111, acc_o);
        chk("mem cached", 32'h1, {31'h0, cc});
        unc <= 1'b1;
        go(OP_MEM_READ, SZ_32, 16'h0, 32'h0);
        chk("page uncached", 32'h0, {31'h0, cc});
        cnt <= 32'h0;
        src <= 32'h40;
        go(OP_PORT_STRING_WRITE, SZ_8, 16'h0300, 32'h0);
        chk("zero latency", 32'd1, lat);
        chk("zero src", 32'h40, src_o);
        $display("test string ops done");
        rpt <= 1'b0;
        par_flip <= 1'b1;
        go(OP_PORT_IN, SZ_8, 16'h0300, 32'h0);
        chk("port parity", 32'h1, {31'h0, pe});
        par_flip <= 1'b0;
        maddr <= 32'h00010000;
        go(OP_MEM_READ, SZ_32, 16'h0, 32'h0);
        chk("mapped port", 32'hefb2c35a, acc_o);
        $display("test parity and mapping done");
        close_out();
    end
endmodule
`default_nettype wire
